// >>> readout_link_params.svh
// constants for the readout link packet router: characters, offsets, reset values
`ifndef READOUT_LINK_PARAMS_SVH
`define READOUT_LINK_PARAMS_SVH

// ****************************************************************
// 8b/10b control characters, unencoded byte values
// ****************************************************************
`define K28_0 8'h1c
`define K28_1 8'h3c
`define K28_2 8'h5c
`define K28_3 8'h7c
`define K28_4 8'h9c
`define K28_5 8'hbc
`define K28_6 8'hdc
`define K23_7 8'hf7
`define K27_7 8'hfb
`define K29_7 8'hfd
`define K30_7 8'hfe
`define COMMA_WORD 16'hbc3c

// ****************************************************************
// packet layout
// ****************************************************************
`define PKT_LAST 3'h7
`define TX_LAST_STEP 4'h8
`define HOP_MSB 15
`define HOP_LSB 12
`define DCS_WRITE_BIT 8
`define CAL_PARTITION 8'hff
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h1021

// ****************************************************************
// register offsets and reset values
// ****************************************************************
`define ADDR_CTRL 8'h00
`define ADDR_DCNT 8'h04
`define ADDR_PATTERN 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_TS_LO 8'h10
`define ADDR_TS_HI 8'h14
`define CTRL_RESET 2'h3
`define DCNT_RESET 8'h00
`define PATTERN_RESET 16'h0000

`endif

// >>> readout_link_pkg.sv
// types shared by the readout link packet router
package readout_link_pkg;

  // one link word: two k flags (high, low) and two bytes
  typedef struct packed {
    logic [1:0]  isk;
    logic [15:0] data;
  } link_word_type;

  // eight 16-bit words, word 0 first
  typedef logic [7:0][15:0] pkt_type;

  // settings applied at a system clock edge
  typedef struct packed {
    logic [47:0] ts;
    logic [7:0]  partition;
    logic [15:0] cal_time;
    logic        cal_event;
  } frame_cfg_type;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_DCS  = 2'b01,
    E_HDR  = 2'b10,
    E_DATA = 2'b11
  } engine_state_type;

endpackage

// >>> readout_link_packet_router.sv
// two-port packet router of the front_end_controller optical link
// Functional notes
// R1: every packet is eight 16-bit words framed by control characters
// R2: idle transmitter sends comma pairs to keep alignment
// R3: receiver drops comma words anywhere without disturbing assembly
// R4: one two-k-character type word precedes each packet, steers it, is not stored
// R5: request types: high K28.0, low K28.2 slow control, K28.3 readout, K28.4 data
// R6: reply types: high K28.0, low K23.7 slow control, K27.7 header, K29.7 data
// R7: slow_control_channel request carries address, and for writes eight data bytes
// R8: slow_control_channel reply returns the address and eight data bytes
// R9: readout requests are broadcast and processed by every controller
// R10: host sends one readout request per system clock period
// R11: readout request settings apply to the next system clock period
// R12: calibration partition carries the internal injection timestamp
// R13: data request is answered by one header plus needed data packets
// R14: header holds timestamp, partition, data packet count and status
// R15: a header is always sent, even with no data
// R16: at most 255 data packets follow a header
// R17: last data packet carries group crc and is full length
// R18: hop_count 1..15 forwards with hop_count minus one; local only if broadcast
// R19: hop_count zero is processed locally and not forwarded
// R20: replies leave on the port where the request arrived
// R21: reply packets pass unchanged to the other port
// R22: two equivalent ports, either carries control and readout
// R23: system timestamp is six bytes, one step per system clock
// R24: reserved or unknown types are dropped with no reply
// R25: whole packets only; commas only between words
`include "readout_link_params.svh"

module readout_link_packet_router (
  // ahb-lite slave
  input  wire logic                                hclk,
  input  wire logic                                hresetn,
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic [31:0]                              hrdata,
  output logic                                     hreadyout,
  output logic                                     hresp,
  // two link ports, words move on the rising link clock
  input  wire logic [1:0]                          link_clk,
  input  wire readout_link_pkg::link_word_type [1:0] rx_word,
  output readout_link_pkg::link_word_type [1:0]    tx_word,
  // beam-synchronous system clock and settings for the running period
  input  wire logic                                sys_clk,
  output readout_link_pkg::frame_cfg_type          frame_cfg
);
  import readout_link_pkg::*;

  // ****************************************************************
  // register bus
  // ****************************************************************
  logic [31:0]   hrdata_q;
  logic          wr_pend_q;
  logic [7:0]    wr_addr_q;
  logic [1:0]    ctrl_q;
  logic [7:0]    dcnt_q;
  logic [15:0]   pattern_q;
  logic [7:0]    drops_q;
  frame_cfg_type cfg_q;
  frame_cfg_type cfg_pend_q;
  engine_state_type eng_q;
  wire           addr_ok = hsel & htrans[1] & hready;
  logic [31:0]   rd_val;

  always_comb begin
    unique case (haddr[7:0])
      `ADDR_CTRL:    rd_val = {30'h0000_0000, ctrl_q};
      `ADDR_DCNT:    rd_val = {24'h00_0000, dcnt_q};
      `ADDR_PATTERN: rd_val = {16'h0000, pattern_q};
      `ADDR_STATUS:  rd_val = {15'h0000, eng_q != E_IDLE, drops_q, cfg_q.partition};
      `ADDR_TS_LO:   rd_val = cfg_q.ts[31:0];
      `ADDR_TS_HI:   rd_val = {16'h0000, cfg_q.ts[47:32]};
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  // zero wait states: read data is fetched in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q  <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok) wr_addr_q <= haddr[7:0];
      if (addr_ok & ~hwrite) hrdata_q <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= `CTRL_RESET;
      dcnt_q    <= `DCNT_RESET;
      pattern_q <= `PATTERN_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `ADDR_CTRL) ctrl_q <= hwdata[1:0];
      if (wr_addr_q == `ADDR_DCNT) dcnt_q <= hwdata[7:0];
      if (wr_addr_q == `ADDR_PATTERN) pattern_q <= hwdata[15:0];
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************************************
  // synchronisers and link clock edges
  // ****************************************************************
  logic [1:0]    lclk_s1_q, lclk_s2_q, lclk_s3_q;
  link_word_type [1:0] rx_s1_q, rx_s2_q;
  logic [2:0]    sys_s_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lclk_s1_q <= 2'h0;
      lclk_s2_q <= 2'h0;
      lclk_s3_q <= 2'h0;
      rx_s1_q   <= '0;
      rx_s2_q   <= '0;
      sys_s_q   <= 3'h0;
    end else begin
      lclk_s1_q <= link_clk;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
      rx_s1_q   <= rx_word;
      rx_s2_q   <= rx_s1_q;
      sys_s_q   <= {sys_s_q[1:0], sys_clk};
    end
  end

  wire [1:0] lrise  = lclk_s2_q & ~lclk_s3_q;
  wire       sys_up = sys_s_q[1] & ~sys_s_q[2];

  // ****************************************************************
  // receive: assemble eight words behind a type word
  // ****************************************************************
  pkt_type    rx_buf_q [2];
  logic [7:0] rx_type_q [2];
  logic [2:0] rx_cnt_q [2];
  logic       rx_act_q [2];
  logic       rx_done_q [2];
  logic [1:0] rx_clr;

  genvar g;
  for (g = 0; g < 2; g++) begin : g_rx
    wire logic [15:0] d     = rx_s2_q[g].data;
    wire logic        ctl   = rx_s2_q[g].isk == 2'h3;
    wire logic        comma = ctl & (d[15:8] == `K28_5 | d[15:8] == `K28_1 | d[7:0] == `K28_1 | d[7:0] == `K28_5);
    wire logic        tword = ctl & ~comma & d[15:8] == `K28_0;
    wire logic        take  = lrise[g] & ctrl_q[g];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rx_buf_q[g]  <= '0;
        rx_type_q[g] <= 8'h00;
        rx_cnt_q[g]  <= 3'h0;
        rx_act_q[g]  <= 1'b0;
        rx_done_q[g] <= 1'b0;
      end else begin
        if (rx_clr[g]) rx_done_q[g] <= 1'b0;
        if (take & ~comma) begin // R3
          if (tword) begin // R4
            rx_act_q[g]  <= 1'b1;
            rx_type_q[g] <= d[7:0];
            rx_cnt_q[g]  <= 3'h0;
          end else if (rx_s2_q[g].isk == 2'h0 && rx_act_q[g]) begin
            rx_buf_q[g][rx_cnt_q[g]] <= d;
            rx_cnt_q[g] <= rx_cnt_q[g] + 3'h1;
            if (rx_cnt_q[g] == `PKT_LAST) begin // R1
              rx_act_q[g]  <= 1'b0;
              rx_done_q[g] <= 1'b1;
            end
          end else begin
            rx_act_q[g] <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************************************
  // dispatch: port 0 first, one packet per cycle
  // ****************************************************************
  wire       disp_v    = rx_done_q[0] | rx_done_q[1];
  wire       disp_port = ~rx_done_q[0];
  assign rx_clr = {disp_v & disp_port, disp_v & ~disp_port};
  pkt_type   dpkt;
  assign dpkt = rx_buf_q[disp_port];
  wire [7:0] dtype  = rx_type_q[disp_port];
  wire [3:0] hop    = dpkt[0][`HOP_MSB:`HOP_LSB];
  wire       is_dcs = dtype == `K28_2; // R5
  wire       is_ro  = dtype == `K28_3;
  wire       is_dr  = dtype == `K28_4;
  wire       is_req = is_dcs | is_ro | is_dr;
  wire       is_rep = dtype == `K23_7 | dtype == `K27_7 | dtype == `K29_7; // R6
  wire       fwd_go   = disp_v & ((is_req & hop != 4'h0) | is_rep); // R18 R21 R24
  wire       local_go = disp_v & is_req & (hop == 4'h0 | is_ro); // R9 R19
  wire       eng_go   = local_go & (is_dcs | is_dr);
  wire       dst      = ~disp_port;
  wire [15:0] fwd_w0  = is_req ? {hop - 4'h1, dpkt[0][11:0]} : dpkt[0]; // R18

  // ****************************************************************
  // forward buffers, one packet per outgoing port
  // ****************************************************************
  pkt_type    fwd_buf_q [2];
  logic [7:0] fwd_type_q [2];
  logic       fwd_v_q [2];
  logic [1:0] tx_fdone_q, tx_gdone_q;
  wire        fwd_drop = fwd_go & fwd_v_q[dst];

  for (g = 0; g < 2; g++) begin : g_fwd
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        fwd_buf_q[g]  <= '0;
        fwd_type_q[g] <= 8'h00;
        fwd_v_q[g]    <= 1'b0;
      end else if (fwd_go && dst == g && !fwd_v_q[g]) begin // R21
        fwd_buf_q[g]  <= {dpkt[7:1], fwd_w0};
        fwd_type_q[g] <= dtype;
        fwd_v_q[g]    <= 1'b1;
      end else if (tx_fdone_q[g]) begin
        fwd_v_q[g] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // reply engine and slow control store
  // ****************************************************************
  logic [63:0] sc_mem_q [4];
  logic        gen_port_q;
  logic [15:0] gen_addr_q;
  logic [63:0] gen_data_q;
  logic [47:0] gen_ts_q;
  logic [7:0]  gen_cnt_q, gen_left_q, gen_idx_q;
  logic [15:0] crc_q;
  wire         gen_done = tx_gdone_q[gen_port_q];
  wire         wr_sc    = eng_go & is_dcs & eng_q == E_IDLE & dpkt[0][`DCS_WRITE_BIT];
  wire [63:0]  req_data = {dpkt[2], dpkt[3], dpkt[4], dpkt[5]};
  wire         eng_drop = eng_go & eng_q != E_IDLE;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int b = 15; b >= 0; b--) begin
      r = (r[15] ^ w[b]) ? {r[14:0], 1'b0} ^ `CRC_POLY : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  always_ff @(posedge hclk) begin
    if (wr_sc) sc_mem_q[dpkt[1][1:0]] <= req_data; // R7
  end

  pkt_type     payload, gen_pkt;
  logic [15:0] crc7;
  logic [7:0]  gen_type;
  wire         gen_last = gen_left_q == 8'h01;

  always_comb begin
    crc7 = crc_q;
    for (int i = 0; i < 8; i++) begin
      payload[i] = pattern_q ^ {gen_idx_q, 8'(i)};
    end
    for (int i = 0; i < 7; i++) begin
      crc7 = crc_step(crc7, payload[i]);
    end
    gen_pkt  = '0;
    gen_type = `K29_7;
    unique case (eng_q)
      E_IDLE: gen_type = `K29_7;
      E_DCS: begin // R8
        gen_type = `K23_7;
        gen_pkt  = {32'h0000_0000, gen_data_q[15:0], gen_data_q[31:16], gen_data_q[47:32],
                    gen_data_q[63:48], gen_addr_q, 16'h0000};
      end
      E_HDR: begin // R14
        gen_type = `K27_7;
        gen_pkt  = {32'h0000_0000, {8'h00, drops_q}, {8'h00, cfg_q.partition},
                    gen_ts_q[15:0], gen_ts_q[31:16], gen_ts_q[47:32], {8'h00, gen_cnt_q}};
      end
      E_DATA: begin // R17
        gen_pkt = payload;
        if (gen_last) gen_pkt[7] = crc7;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_q      <= E_IDLE;
      gen_port_q <= 1'b0;
      gen_addr_q <= 16'h0000;
      gen_data_q <= 64'h0000_0000_0000_0000;
      gen_ts_q   <= 48'h0000_0000_0000;
      gen_cnt_q  <= 8'h00;
      gen_left_q <= 8'h00;
      gen_idx_q  <= 8'h00;
      crc_q      <= `CRC_INIT;
    end else if (eng_go && eng_q == E_IDLE) begin
      gen_port_q <= disp_port; // R20
      if (is_dcs) begin
        eng_q      <= E_DCS;
        gen_addr_q <= dpkt[1];
        gen_data_q <= dpkt[0][`DCS_WRITE_BIT] ? req_data : sc_mem_q[dpkt[1][1:0]];
      end else begin
        eng_q      <= E_HDR; // R13 R15
        gen_ts_q   <= {dpkt[1], dpkt[2], dpkt[3]};
        gen_cnt_q  <= dcnt_q; // R16
        gen_left_q <= dcnt_q;
        gen_idx_q  <= 8'h00;
        crc_q      <= `CRC_INIT;
      end
    end else if (gen_done) begin
      unique case (eng_q)
        E_IDLE: eng_q <= E_IDLE;
        E_DCS:  eng_q <= E_IDLE;
        E_HDR:  eng_q <= (gen_left_q == 8'h00) ? E_IDLE : E_DATA;
        E_DATA: begin
          crc_q      <= crc_step(crc7, payload[7]);
          gen_left_q <= gen_left_q - 8'h01;
          gen_idx_q  <= gen_idx_q + 8'h01;
          if (gen_last) eng_q <= E_IDLE;
        end
      endcase
    end
  end

  // a request that finds the engine or forward buffer busy is lost and counted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) drops_q <= 8'h00;
    else if (eng_drop | fwd_drop) drops_q <= drops_q + 8'h01;
  end

  // ****************************************************************
  // readout settings, applied at the next system clock edge
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_pend_q <= '0;
      cfg_q      <= '0;
    end else begin
      if (local_go & is_ro) begin // R12
        cfg_pend_q.ts        <= {dpkt[1], dpkt[2], dpkt[3]};
        cfg_pend_q.partition <= dpkt[0][7:0];
        cfg_pend_q.cal_time  <= dpkt[4];
        cfg_pend_q.cal_event <= dpkt[0][7:0] == `CAL_PARTITION;
      end
      if (sys_up) cfg_q <= cfg_pend_q; // R11
    end
  end

  assign frame_cfg = cfg_q;

  // ****************************************************************
  // transmit: forwarded packets first, then replies, else commas
  // ****************************************************************
  logic [3:0]    tx_step_q [2];
  logic          tx_src_q [2];
  link_word_type tx_q [2];

  for (g = 0; g < 2; g++) begin : g_tx
    wire logic    gen_rdy = eng_q != E_IDLE && gen_port_q == g;
    wire pkt_type cur     = tx_src_q[g] ? gen_pkt : fwd_buf_q[g];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        tx_step_q[g]  <= 4'h0;
        tx_src_q[g]   <= 1'b0;
        tx_q[g]       <= '{isk: 2'h3, data: `COMMA_WORD};
        tx_fdone_q[g] <= 1'b0;
        tx_gdone_q[g] <= 1'b0;
      end else begin
        tx_fdone_q[g] <= 1'b0;
        tx_gdone_q[g] <= 1'b0;
        if (lrise[g]) begin
          if (tx_step_q[g] != 4'h0) begin // R25
            tx_q[g]      <= '{isk: 2'h0, data: cur[3'(tx_step_q[g] - 4'h1)]};
            tx_step_q[g] <= (tx_step_q[g] == `TX_LAST_STEP) ? 4'h0 : tx_step_q[g] + 4'h1;
            if (tx_step_q[g] == `TX_LAST_STEP) begin
              tx_fdone_q[g] <= ~tx_src_q[g];
              tx_gdone_q[g] <= tx_src_q[g];
            end
          end else if (ctrl_q[g] && fwd_v_q[g]) begin // R22
            tx_src_q[g]  <= 1'b0;
            tx_step_q[g] <= 4'h1;
            tx_q[g]      <= '{isk: 2'h3, data: {`K28_0, fwd_type_q[g]}};
          end else if (ctrl_q[g] && gen_rdy) begin
            tx_src_q[g]  <= 1'b1;
            tx_step_q[g] <= 4'h1;
            tx_q[g]      <= '{isk: 2'h3, data: {`K28_0, gen_type}};
          end else begin
            tx_q[g] <= '{isk: 2'h3, data: `COMMA_WORD}; // R2
          end
        end
      end
    end
    assign tx_word[g] = tx_q[g];

    a_idle_comma: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      lrise[g] && tx_step_q[g] == 4'h0 && !fwd_v_q[g] && !gen_rdy |=> tx_q[g].data == `COMMA_WORD)
      else $error("idle port did not send a comma pair");
    a_packet_length: assert property (@(posedge hclk) disable iff (!hresetn) // R1
      $rose(tx_fdone_q[g] | tx_gdone_q[g]) |-> $past(tx_step_q[g]) == `TX_LAST_STEP && tx_step_q[g] == 4'h0)
      else $error("packet did not end after eight words");
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_hop_req;
    disp_v && is_req && hop != 4'h0 && !fwd_v_q[dst];
  endsequence

  // one cycle after dispatch: the outgoing forward buffer was not newly loaded
  sequence s_not_forwarded;
    !fwd_v_q[$past(dst)] || $past(fwd_v_q[dst]);
  endsequence

  a_hop_forward: assert property (@(posedge hclk) disable iff (!hresetn) // R18
    s_hop_req |=> fwd_v_q[$past(dst)] && fwd_buf_q[$past(dst)][0][15:12] == $past(hop) - 4'h1)
    else $error("forwarded request hop count not reduced by one");
  a_hop_zero_local: assert property (@(posedge hclk) disable iff (!hresetn) // R19
    disp_v && is_req && hop == 4'h0 |-> local_go ##1 s_not_forwarded)
    else $error("hop zero request forwarded or not processed");
  a_reply_port: assert property (@(posedge hclk) disable iff (!hresetn) // R20
    eng_go && eng_q == E_IDLE |=> gen_port_q == $past(disp_port) && eng_q != E_IDLE)
    else $error("reply engine not bound to request port");
  a_reply_pass: assert property (@(posedge hclk) disable iff (!hresetn) // R21
    disp_v && is_rep && !fwd_v_q[dst] |=> fwd_type_q[$past(dst)] == $past(dtype))
    else $error("reply packet not passed to the other port");
  a_header_always: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    eng_go && is_dr && eng_q == E_IDLE |=> eng_q == E_HDR ##0 gen_cnt_q == $past(dcnt_q))
    else $error("data request did not start a header");
  a_reserved_drop: assert property (@(posedge hclk) disable iff (!hresetn) // R24
    disp_v && !is_req && !is_rep |-> !local_go ##1 s_not_forwarded)
    else $error("reserved packet type was acted on");
  a_next_period: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    sys_up |=> cfg_q == $past(cfg_pend_q))
    else $error("readout settings not applied at system clock edge");
  a_broadcast_local: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    disp_v && is_ro |-> local_go ##1 cfg_pend_q.partition == $past(dpkt[0][7:0]))
    else $error("readout request not processed locally");

endmodule // readout_link_packet_router

// >>> link_far_end.sv
// far-end link model: free-running link clocks, packet sender and tx packet collector
`include "readout_link_params.svh"

module link_far_end (
  // link side of the router
  output logic [1:0]                                 link_clk,
  output readout_link_pkg::link_word_type [1:0]      rx_word,
  input  wire readout_link_pkg::link_word_type [1:0] tx_word
);
  timeunit 1ns;
  timeprecision 1ps;
  import readout_link_pkg::*;

  logic [136:0]  got_q [$];
  int            frame_errs = 0;
  link_word_type comma_w;
  assign comma_w = '{isk: 2'b11, data: `COMMA_WORD};

  // ****************************************************************
  // clocks run free: an idle link still carries comma pairs
  // ****************************************************************
  initial begin
    link_clk = 2'b00;
    rx_word  = {2'b11, `COMMA_WORD, 2'b11, `COMMA_WORD};
  end
  always #80 link_clk[0] = ~link_clk[0];
  initial begin
    #53;
    forever #80 link_clk[1] = ~link_clk[1];
  end

  for (genvar p = 0; p < 2; p++) begin : g_col
    int         cnt = -1;
    logic [7:0] ty;
    pkt_type    pk;
    always @(posedge link_clk[p]) begin
      if (tx_word[p].isk == 2'b11 && tx_word[p].data[15:8] == `K28_0) begin
        if (cnt >= 0) frame_errs++;
        cnt = 0;
        ty  = tx_word[p].data[7:0];
      end else if (tx_word[p].isk == 2'b00 && cnt >= 0) begin
        pk[cnt] = tx_word[p].data;
        cnt++;
        if (cnt == 8) begin
          got_q.push_back({1'(p), ty, pk});
          cnt = -1;
        end
      end else if (tx_word[p] !== comma_w) frame_errs++;
    end
  end

  // words change on the falling link clock, away from the sampling edge
  task automatic send_pkt(input int p, input logic [7:0] ty, input pkt_type pk);
    link_word_type seq [$];
    seq.push_back('{2'b11, {`K28_0, ty}});
    for (int i = 0; i < 8; i++) begin
      seq.push_back('{2'b00, pk[i]});
      if (i == 3) seq.push_back(comma_w);
    end
    seq.push_back(comma_w);
    foreach (seq[i]) begin
      @(negedge link_clk[p]);
      rx_word[p] <= seq[i];
    end
  endtask
endmodule // link_far_end

// >>> tb_top.sv
// self-checking bench of the readout link packet router
`include "readout_link_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import readout_link_pkg::*;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end

  typedef struct {
    int          ip;
    logic [7:0]  ty;
    pkt_type     pk;
    int          n;
    logic        ep;
    logic [7:0]  ety;
    logic [63:0] ew;
  } row_type;

  logic                       hclk, hresetn, hsel, hwrite, hready, sys_clk;
  logic [31:0]                haddr, hwdata, hrdata;
  logic [1:0]                 htrans, link_clk;
  logic [2:0]                 hsize;
  logic                       hreadyout, hresp;
  link_word_type [1:0]        rx_word, tx_word;
  frame_cfg_type              frame_cfg;
  int                         bad_count = 0;
  int                         tests_run = 0;
  row_type                    rows [9];

  assign hready = hreadyout;

  readout_link_packet_router u_readout_link_packet_router (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk), .rx_word(rx_word),
    .tx_word(tx_word), .sys_clk(sys_clk), .frame_cfg(frame_cfg));

  link_far_end u_link_far_end (.link_clk(link_clk), .rx_word(rx_word), .tx_word(tx_word));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ****************************************************************
  // bus master and closing
  // ****************************************************************
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // reference crc over the first n payload words of a group, pattern left at zero
  function automatic logic [15:0] crc_ref(input int n);
    logic [15:0] c;
    logic [15:0] w;
    c = `CRC_INIT;
    for (int k = 0; k < n; k++) begin
      w = {8'(k / 8), 8'(k % 8)};
      for (int b = 15; b >= 0; b--) begin
        c = (c[15] ^ w[b]) ? {c[14:0], 1'b0} ^ `CRC_POLY : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  initial begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    end_sim;
  end

  initial begin
    logic [136:0] got;
    logic [31:0]  rd;
    hresetn = 1'b0;
    {hsel, hwrite, sys_clk, htrans, haddr, hwdata} = '0;
    hsize   = 3'b010;
    rows = '{
      '{0, `K28_3, 128'h0003_0002_0001_2005, 1, 1, `K28_3, 64'h0003_0002_0001_1005},
      '{1, `K28_2, 128'h4444_3333_2222_1111_0002_0100, -1, 1, 8'h00, 64'h0},
      '{1, `K28_2, 128'h0002_0000, 1, 1, `K23_7, 64'h2222_1111_0002_0000},
      '{0, `K28_4, 128'h000c_000b_000a_0000, 1, 0, `K27_7, 64'h000c_000b_000a_0000},
      '{0, `K29_7, 128'hbeef_abcd, 1, 1, `K29_7, 64'hbeef_abcd},
      '{1, `K28_6, 128'h0, 0, 0, 8'h00, 64'h0},
      '{0, `K30_7, 128'h1234, 0, 0, 8'h00, 64'h0},
      '{1, `K28_3, 128'h0123_0009_0008_0007_00ff, 0, 0, 8'h00, 64'h0},
      '{1, `K28_4, 128'h0003_0002_0001_3000, 1, 0, `K28_4, 64'h0003_0002_0001_2000}};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK(tx_word, {2{2'b11, `COMMA_WORD}})
    ahb(1'b0, 32'h0000_0000, 32'h0, rd);
    `CHK(rd[1:0], 2'h3)
    ahb(1'b0, 32'h0000_0004, 32'h0, rd);
    `CHK(rd[7:0], 8'h00)
    ahb(1'b0, 32'h0000_0040, 32'h0, rd);
    `CHK({hresp, hreadyout, rd}, {2'b01, 32'h0000_0000})
    foreach (rows[r]) begin
      u_link_far_end.got_q.delete();
      u_link_far_end.send_pkt(rows[r].ip, rows[r].ty, rows[r].pk);
      repeat (400) @(posedge hclk);
      if (rows[r].n >= 0) `CHK(u_link_far_end.got_q.size(), rows[r].n)
      if (rows[r].n == 1) begin
        got = u_link_far_end.got_q[0];
        `CHK(got[136:128], {rows[r].ep, rows[r].ety})
        `CHK(got[63:0], rows[r].ew)
      end
    end
    // the readout settings must wait for the next system clock edge
    `CHK(frame_cfg.partition, 8'h00)
    sys_clk <= 1'b1;
    repeat (20) @(posedge hclk);
    sys_clk <= 1'b0;
    repeat (5) @(posedge hclk);
    `CHK(frame_cfg, {48'h0007_0008_0009, 8'hff, 16'h0123, 1'b1})
    ahb(1'b1, 32'h0000_0004, 32'h0000_0002, rd);
    u_link_far_end.got_q.delete();
    u_link_far_end.send_pkt(0, `K28_4, 128'h0005_0006_0007_0000);
    repeat (600) @(posedge hclk);
    `CHK(u_link_far_end.got_q.size(), 3)
    got = u_link_far_end.got_q[0];
    `CHK({got[136:128], got[79:64], got[15:0]}, {1'b0, `K27_7, 16'h00ff, 16'h0002})
    `CHK(u_link_far_end.got_q[1][136:128], {1'b0, `K29_7})
    `CHK(u_link_far_end.got_q[2][136:128], {1'b0, `K29_7})
    `CHK(u_link_far_end.got_q[2][127:112], crc_ref(15))
    // a request sent just after a system clock rise only takes effect at the next rise
    sys_clk <= 1'b1;
    u_link_far_end.send_pkt(0, `K28_3, 128'h0003_0002_0001_0012);
    repeat (20) @(posedge hclk);
    `CHK(frame_cfg.partition, 8'hff)
    sys_clk <= 1'b0;
    repeat (20) @(posedge hclk);
    sys_clk <= 1'b1;
    repeat (5) @(posedge hclk);
    `CHK(frame_cfg, {48'h0001_0002_0003, 8'h12, 16'h0000, 1'b0})
    ahb(1'b1, 32'h0000_0000, 32'h0000_0002, rd);
    u_link_far_end.got_q.delete();
    u_link_far_end.send_pkt(0, `K28_3, 128'h0003_0002_0001_1005);
    repeat (400) @(posedge hclk);
    `CHK(u_link_far_end.got_q.size(), 0)
    ahb(1'b1, 32'h0000_0000, 32'h0000_0003, rd);
    `CHK(u_link_far_end.frame_errs, 0)
    end_sim;
  end
endmodule // tb_top
